// ===== include/eib_pkg.sv
// Purpose: Constants for the indirect low power idle register bank
// Assumes: Byte wide indirect access, 25 MHz core clock
// Notes: Even offset holds bits 15:8 of a word, odd offset bits 7:0
package eib_pkg;
    // ==========================================================
    // Access window
    localparam logic [7:0] A_SEL = 8'h6e;
    localparam logic [7:0] A_OFS = 8'h6f;
    localparam logic [7:0] A_DATA = 8'ha0;
    localparam logic [2:0] SPACE_EEE = 3'h1;
    localparam logic [3:0] PSEL_GLOBAL = 4'h0;
    localparam logic [3:0] PSEL_P3 = 4'h3;
    localparam logic [3:0] PSEL_P4 = 4'h4;
    // ==========================================================
    // Word offsets
    localparam logic [7:0] O_EXP = 8'h0c;
    localparam logic [7:0] O_EXP_LO = 8'h0d;
    localparam logic [7:0] O_TXNP = 8'h0e;
    localparam logic [7:0] O_LPNP = 8'h10;
    localparam logic [7:0] O_CAP = 8'h28;
    localparam logic [7:0] O_WERR = 8'h2a;
    localparam logic [7:0] O_WERR_LO = 8'h2b;
    localparam logic [7:0] O_PCTL = 8'h2c;
    localparam logic [7:0] O_QMB = 8'h30;
    localparam logic [7:0] O_WAIT = 8'h32;
    localparam logic [7:0] O_DIAG = 8'h34;
    localparam logic [7:0] O_MINLPI = 8'h36;
    localparam logic [7:0] O_WTHR = 8'h38;
    localparam logic [7:0] O_DCTL = 8'h3a;
    // ==========================================================
    // Fixed and reset values
    localparam logic [7:0] QMB_HI = 8'h40;
    localparam logic [6:0] QMB_LO = 7'h10;
    localparam logic [15:0] WAIT_RST = 16'h0010;
    localparam logic [7:0] DIAG_HI = 8'h68;
    localparam logic [3:0] DIAG_MID = 4'h0;
    localparam logic [3:0] NP_EN_RST = 4'hf;
    localparam logic [15:0] MINLPI_VAL = 16'h0000;
    localparam logic [15:0] WAKE_THR = 16'h0201;
    localparam logic [15:0] DCTL_VAL = 16'h0001;
    localparam logic [15:0] TXNP_RST = 16'h2001;
    localparam logic [15:0] TXNP_WMASK = 16'hb7ff;
    localparam logic [15:0] ACK_MASK = 16'h4000;
    localparam logic [8:0] EXP_RSVD = 9'h000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    // ==========================================================
    // Bit positions
    localparam int B_TERM = 7;
    localparam int B_TGL = 11;
    localparam int B_ACK = 14;
    localparam int B_HWNP = 7;
    localparam int B_DIS10 = 7;
    localparam int B_SWMODE = 1;
    localparam int B_EN100 = 0;
    localparam int B_CAPLOC = 1;
    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 25;
    localparam int LPI_UNIT_US = 1300;
    localparam int LPI_UNIT_CYC = LPI_UNIT_US * CLK_MHZ;
    localparam logic [1:0] FLP_LAST = 2'h2;
    localparam logic [1:0] FLP_MAX = 2'h3;
endpackage : eib_pkg

// ===== hdl/eib_eee_bank.sv
// Purpose: Indirect register bank for low power idle on copper ports 3, 4
// Assumes: Event inputs come from logic on SYS_CLK
// Notes: Wake time counted in SYS_CLK cycles of 40 ns
// ==============================================================
`timescale 1ns/100ps
`default_nettype none
module eib_eee_bank #(
    parameter int LPI_UNIT_CYC = eib_pkg::LPI_UNIT_CYC
) (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic CE,
    input wire logic [7:0] ADDR,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] WDATA,
    output logic [7:0] RDATA,
    input wire logic [1:0] TRANSMIT_QUEUE_EMPTY,
    input wire logic [1:0] TRAFFIC_IN,
    input wire logic [1:0] CAP_MATCH,
    input wire logic [1:0] PD_FAULT,
    input wire logic [1:0] RX_PAGE_VALID,
    input wire logic [1:0][15:0] RX_PAGE_WORD,
    input wire logic [1:0] PARTNER_AN_ABLE,
    input wire logic [1:0] PARTNER_NP_ABLE,
    input wire logic [1:0] AN_START,
    input wire logic [1:0] BASE_TOGGLE,
    input wire logic [1:0] PAGE_SENT,
    input wire logic [1:0] WAKE_BUSY,
    output logic [1:0] LPI_REQ,
    output logic [1:0] EEE100_EN,
    output logic [3:0] NP_ENABLE,
    output logic [1:0][15:0] NP_TX_WORD
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SRST);

    function automatic logic [15:0] put_byte(input logic [15:0] w, input logic h,
                                              input logic [7:0] b);
        put_byte = h ? {b, w[7:0]} : {w[15:8], b};
    endfunction : put_byte

    logic [7:0] sel;
    logic [7:0] ofs;
    logic term_en;
    logic [15:0] wait_time;
    logic [1:0] pdf;
    logic [1:0] pgr;
    logic [1:0] cap_loc;
    logic [1:0] dis10;
    logic [1:0] hw_np;
    logic [1:0] hw_stat;
    logic [1:0] sw_mode;
    logic [1:0][15:0] lpnp;
    logic [1:0][15:0] werr;
    logic [1:0][15:0] prev_rx;
    logic [1:0][1:0] burst_cnt;
    logic [1:0][15:0] wake_cnt;
    logic [1:0][15:0] pre;
    logic [1:0][15:0] units;
    logic eee_sp;
    logic glob;
    logic [1:0] port_hit;
    logic dacc_wr;
    logic dacc_rd;
    logic hi;
    logic [7:0] word_ofs;
    logic [15:0] rd_word;
    logic [1:0] rc_exp;
    logic [1:0] rc_werr;
    logic [1:0] page_done;
    logic pi;

    // ==========================================================
    // Access decode
    always_comb begin
        eee_sp = sel[7:5] == eib_pkg::SPACE_EEE;
        glob = eee_sp && sel[3:0] == eib_pkg::PSEL_GLOBAL;
        port_hit[0] = eee_sp && sel[3:0] == eib_pkg::PSEL_P3;
        port_hit[1] = eee_sp && sel[3:0] == eib_pkg::PSEL_P4;
        dacc_wr = WR && ADDR == eib_pkg::A_DATA;
        dacc_rd = RD && ADDR == eib_pkg::A_DATA;
        hi = !ofs[0];
        word_ofs = {ofs[7:1], 1'b0};
        pi = port_hit[1];
        rc_exp = {2{dacc_rd && ofs == eib_pkg::O_EXP_LO}} & port_hit;
        rc_werr = {2{dacc_rd && ofs == eib_pkg::O_WERR_LO}} & port_hit;
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            sel <= 8'h00;
            ofs <= 8'h00;
        end else if (CE) begin
            if (WR && ADDR == eib_pkg::A_SEL) begin
                sel <= WDATA;
            end else if (WR && ADDR == eib_pkg::A_OFS) begin
                ofs <= WDATA;
            end
        end
    end

    // ==========================================================
    // Global registers; reserved fields are constants, so writes drop
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            term_en <= 1'b0;
            wait_time <= eib_pkg::WAIT_RST;
            NP_ENABLE <= eib_pkg::NP_EN_RST;
        end else if (CE && dacc_wr && glob) begin
            if (word_ofs == eib_pkg::O_QMB && !hi) begin
                term_en <= WDATA[eib_pkg::B_TERM];
            end else if (word_ofs == eib_pkg::O_WAIT) begin
                wait_time <= put_byte(wait_time, hi, WDATA);
            end else if (word_ofs == eib_pkg::O_DIAG && !hi) begin
                NP_ENABLE <= WDATA[3:0];
            end
        end
    end

    // ==========================================================
    // Read path
    always_comb begin
        rd_word = 16'h0000;
        if (glob) begin
            if (word_ofs == eib_pkg::O_QMB) begin
                rd_word = {eib_pkg::QMB_HI, term_en, eib_pkg::QMB_LO};
            end else if (word_ofs == eib_pkg::O_WAIT) begin
                rd_word = wait_time;
            end else if (word_ofs == eib_pkg::O_DIAG) begin
                rd_word = {eib_pkg::DIAG_HI, eib_pkg::DIAG_MID, NP_ENABLE};
            end else if (word_ofs == eib_pkg::O_MINLPI) begin
                rd_word = eib_pkg::MINLPI_VAL;
            end else if (word_ofs == eib_pkg::O_WTHR) begin
                rd_word = eib_pkg::WAKE_THR;
            end else if (word_ofs == eib_pkg::O_DCTL) begin
                rd_word = eib_pkg::DCTL_VAL;
            end
        end else if (port_hit != 2'b00) begin
            if (word_ofs == eib_pkg::O_EXP) begin
                rd_word = {eib_pkg::EXP_RSVD, 1'b1, 1'b1, pdf[pi],
                           PARTNER_NP_ABLE[pi], 1'b1,
                           pgr[pi], PARTNER_AN_ABLE[pi]};
            end else if (word_ofs == eib_pkg::O_TXNP) begin
                rd_word = NP_TX_WORD[pi];
            end else if (word_ofs == eib_pkg::O_LPNP) begin
                rd_word = lpnp[pi];
            end else if (word_ofs == eib_pkg::O_CAP) begin
                rd_word = {14'h0000, cap_loc[pi], 1'b0};
            end else if (word_ofs == eib_pkg::O_WERR) begin
                rd_word = werr[pi];
            end else if (word_ofs == eib_pkg::O_PCTL) begin
                rd_word = {dis10[pi], 7'h00, hw_np[pi], hw_stat[pi],
                           4'h0, sw_mode[pi], EEE100_EN[pi]};
            end
        end
    end

    // Read data is captured on the same edge that clears, so value goes first
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            RDATA <= 8'h00;
        end else if (CE && RD) begin
            if (ADDR == eib_pkg::A_SEL) begin
                RDATA <= sel;
            end else if (ADDR == eib_pkg::A_OFS) begin
                RDATA <= ofs;
            end else if (ADDR == eib_pkg::A_DATA) begin
                RDATA <= hi ? rd_word[15:8] : rd_word[7:0];
            end else begin
                RDATA <= 8'h00;
            end
        end
    end

    AST_SEL_SPACE: assert property (CE && dacc_wr && !eee_sp |=> $stable(wait_time))
        else $error("Write outside the space changed wait time");
    AST_RD_WAIT: assert property (CE && dacc_rd && glob && ofs == eib_pkg::O_WAIT
        |=> RDATA == $past(wait_time[15:8]))
        else $error("Wait time high byte read wrong");
    AST_NO_PORT1: assert property (CE && dacc_rd && eee_sp && sel[3:0] == 4'h1
        |=> RDATA == 8'h00)
        else $error("Non-copper port read returned data");
    AST_NP_RST: assert property (@(posedge SYS_CLK) disable iff (1'b0)
        SRST |=> NP_ENABLE == eib_pkg::NP_EN_RST)
        else $error("Next page enables not set after reset");
    AST_THR: assert property (CE && dacc_rd && glob && ofs == eib_pkg::O_WTHR + 8'h01
        |=> RDATA == eib_pkg::WAKE_THR[7:0])
        else $error("Wake threshold low byte wrong");

    // ==========================================================
    // Per-port logic, index 0 is port 3 and index 1 is port 4
    for (genvar g = 0; g < 2; g++) begin : g_port
        // Latched status, the set beats a coincident read clear
        always_ff @(posedge SYS_CLK) begin
            if (SRST) begin
                pdf[g] <= 1'b0;
                pgr[g] <= 1'b0;
            end else if (CE) begin
                if (PD_FAULT[g]) begin
                    pdf[g] <= 1'b1;
                end else if (rc_exp[g]) begin
                    pdf[g] <= 1'b0;
                end
                if (page_done[g]) begin
                    pgr[g] <= 1'b1;
                end else if (rc_exp[g]) begin
                    pgr[g] <= 1'b0;
                end
            end
        end

        // Partner page is accepted only on the third matching burst
        assign page_done[g] = RX_PAGE_VALID[g] && burst_cnt[g] == eib_pkg::FLP_LAST &&
            ((RX_PAGE_WORD[g] ^ prev_rx[g]) & ~eib_pkg::ACK_MASK) == 16'h0000;

        always_ff @(posedge SYS_CLK) begin
            if (SRST) begin
                burst_cnt[g] <= 2'h0;
                prev_rx[g] <= 16'h0000;
                lpnp[g] <= 16'h0000;
            end else if (CE && RX_PAGE_VALID[g]) begin
                prev_rx[g] <= RX_PAGE_WORD[g];
                if (((RX_PAGE_WORD[g] ^ prev_rx[g]) & ~eib_pkg::ACK_MASK) != 16'h0000) begin
                    burst_cnt[g] <= 2'h1;
                end else if (burst_cnt[g] != eib_pkg::FLP_MAX) begin
                    burst_cnt[g] <= burst_cnt[g] + 2'h1;
                end
                if (page_done[g]) begin
                    lpnp[g] <= RX_PAGE_WORD[g] | eib_pkg::ACK_MASK;
                end
            end
        end

        // Transmit page; toggle and bit 14 stay under hardware control
        always_ff @(posedge SYS_CLK) begin
            if (SRST) begin
                NP_TX_WORD[g] <= eib_pkg::TXNP_RST;
            end else if (CE) begin
                if (dacc_wr && port_hit[g] && word_ofs == eib_pkg::O_TXNP) begin
                    NP_TX_WORD[g] <= (put_byte(NP_TX_WORD[g], hi, WDATA)
                        & eib_pkg::TXNP_WMASK) | (NP_TX_WORD[g] & ~eib_pkg::TXNP_WMASK);
                end
                if (AN_START[g]) begin
                    NP_TX_WORD[g][eib_pkg::B_TGL] <= ~BASE_TOGGLE[g];
                end else if (PAGE_SENT[g]) begin
                    NP_TX_WORD[g][eib_pkg::B_TGL] <= ~NP_TX_WORD[g][eib_pkg::B_TGL];
                end
            end
        end

        // Port control and capability advertisement
        always_ff @(posedge SYS_CLK) begin
            if (SRST) begin
                dis10[g] <= 1'b1;
                hw_np[g] <= 1'b1;
                hw_stat[g] <= 1'b0;
                sw_mode[g] <= 1'b0;
                EEE100_EN[g] <= 1'b0;
                cap_loc[g] <= 1'b1;
            end else if (CE) begin
                if (dacc_wr && port_hit[g] && word_ofs == eib_pkg::O_PCTL) begin
                    if (hi) begin
                        dis10[g] <= WDATA[eib_pkg::B_DIS10];
                    end else begin
                        hw_np[g] <= WDATA[eib_pkg::B_HWNP];
                        sw_mode[g] <= WDATA[eib_pkg::B_SWMODE];
                        EEE100_EN[g] <= WDATA[eib_pkg::B_EN100];
                    end
                end
                if (dacc_wr && port_hit[g] && ofs == eib_pkg::O_CAP + 8'h01) begin
                    cap_loc[g] <= WDATA[eib_pkg::B_CAPLOC];
                end
                if (hw_np[g] && CAP_MATCH[g]) begin
                    EEE100_EN[g] <= 1'b1;
                    hw_stat[g] <= 1'b1;
                end
            end
        end

        // Wake timing; one error per wake that outlasts the threshold
        always_ff @(posedge SYS_CLK) begin
            if (SRST) begin
                wake_cnt[g] <= 16'h0000;
                werr[g] <= 16'h0000;
            end else if (CE) begin
                if (!WAKE_BUSY[g]) begin
                    wake_cnt[g] <= 16'h0000;
                end else if (wake_cnt[g] != eib_pkg::WAKE_THR + 16'h0001) begin
                    wake_cnt[g] <= wake_cnt[g] + 16'h0001;
                end
                if (WAKE_BUSY[g] && wake_cnt[g] == eib_pkg::WAKE_THR) begin
                    werr[g] <= rc_werr[g] ? 16'h0001 :
                        (werr[g] == eib_pkg::CNT_MAX ? werr[g] : werr[g] + 16'h0001);
                end else if (rc_werr[g]) begin
                    werr[g] <= 16'h0000;
                end
            end
        end

        // Idle request timer; traffic withdraw optional
        always_ff @(posedge SYS_CLK) begin
            if (SRST) begin
                pre[g] <= 16'h0000;
                units[g] <= 16'h0000;
                LPI_REQ[g] <= 1'b0;
            end else if (CE) begin
                if (!TRANSMIT_QUEUE_EMPTY[g] || !EEE100_EN[g]
                    || (term_en && TRAFFIC_IN[g])) begin
                    pre[g] <= 16'h0000;
                    units[g] <= 16'h0000;
                    LPI_REQ[g] <= 1'b0;
                end else begin
                    if (pre[g] == 16'(LPI_UNIT_CYC - 1)) begin
                        pre[g] <= 16'h0000;
                        if (units[g] != eib_pkg::CNT_MAX) begin
                            units[g] <= units[g] + 16'h0001;
                        end
                    end else begin
                        pre[g] <= pre[g] + 16'h0001;
                    end
                    if (units[g] > wait_time) begin
                        LPI_REQ[g] <= 1'b1;
                    end
                end
            end
        end

        AST_TERM: assert property (CE && term_en && TRAFFIC_IN[g] |=> !LPI_REQ[g])
            else $error("Idle request kept despite traffic");
        AST_EN100: assert property (CE && !EEE100_EN[g] |=> !LPI_REQ[g])
            else $error("Idle request without 100BT enable");
        AST_PDF: assert property (CE && PD_FAULT[g]
            |=> pdf[g] ##1 (pdf[g] || $past(rc_exp[g] && CE)))
            else $error("Fault flag lost");
        AST_PGR_ACK: assert property (CE && page_done[g] |=> pgr[g] && lpnp[g][eib_pkg::B_ACK])
            else $error("Page received or ack missing");
        AST_TGL: assert property (CE && PAGE_SENT[g] && !AN_START[g]
            |=> NP_TX_WORD[g][eib_pkg::B_TGL] != $past(NP_TX_WORD[g][eib_pkg::B_TGL]))
            else $error("Toggle did not invert");
        AST_WERR: assert property (CE && WAKE_BUSY[g] && wake_cnt[g] == eib_pkg::WAKE_THR
            && !rc_werr[g] && werr[g] != eib_pkg::CNT_MAX |=> werr[g] == $past(werr[g]) + 16'h0001)
            else $error("Wake error not counted");
        AST_CAP: assert property (CE && hw_np[g] && CAP_MATCH[g] |=> EEE100_EN[g] && hw_stat[g])
            else $error("Capability match did not enable");
    end

endmodule : eib_eee_bank
`default_nettype wire

// ===== testbench/eib_link_partner.sv
// Purpose: Link partner model repeating one next page codeword per burst
// Assumes: One burst a clock while sending, bursts begin after a send pulse
// Notes: Word line shows the inverted last word between bursts
`timescale 1ns/100ps
`default_nettype none
module eib_link_partner (
    input wire logic clk,
    input wire logic send,
    input wire logic [15:0] word,
    input wire logic [3:0] count,
    output logic page_valid,
    output logic [15:0] page_word
);
    logic [3:0] left = 4'h0;
    logic [15:0] held = 16'h0000;
    always_ff @(posedge clk) begin
        if (send) begin
            left <= count;
            held <= word;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end
    end
    // Ack bit flips per burst, so a receiver that compares it never matches
    always_comb begin
        page_valid = (left != 4'h0);
        page_word = ~held;
        if (page_valid) begin
            page_word = held ^ {1'b0, left[0], 14'h0000};
        end
    end
endmodule : eib_link_partner
`default_nettype wire

// ===== testbench/eib_eee_bank_test.sv
// Purpose: Self-checking bench for the indirect low power idle register bank
// Assumes: Short idle unit of 4 cycles, partner on port 3 only
// Notes: Reads are checked from a queue on the falling edge after the edge that samples the strobe
`timescale 1ns/100ps
`default_nettype none
module eib_eee_bank_test;
    localparam int UNIT = 4;
    logic SYS_CLK = 1'b0, SRST = 1'b1, CE = 1'b1, WR = 1'b0, RD = 1'b0;
    logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
    logic [1:0] TRANSMIT_QUEUE_EMPTY = 2'h0, TRAFFIC_IN = 2'h0, CAP_MATCH = 2'h0;
    logic [1:0] PD_FAULT = 2'h0, PARTNER_AN_ABLE = 2'h0, PARTNER_NP_ABLE = 2'h0;
    logic [1:0] AN_START = 2'h0, BASE_TOGGLE = 2'h0, PAGE_SENT = 2'h0, WAKE_BUSY = 2'h0;
    logic [1:0] LPI_REQ, EEE100_EN;
    logic [3:0] NP_ENABLE;
    logic [1:0][15:0] NP_TX_WORD;
    logic lp_send = 1'b0, lp_valid, rd_seen = 1'b0;
    logic [15:0] lp_word = 16'h0000, lp_rx;
    logic [3:0] lp_cnt = 4'h0;
    logic [7:0] exp_q[$];
    int fail_count = 0, cmp_count = 0, cycles = 0;
    logic [15:0] gtab [12] = '{16'h3040, 16'h3110, 16'h3200, 16'h3310, 16'h3468, 16'h350f,
        16'h3600, 16'h3700, 16'h3802, 16'h3901, 16'h3a00, 16'h3b01};
    logic [15:0] ptab [9] = '{16'h0c00, 16'h0e20, 16'h0f01, 16'h1000, 16'h1100, 16'h2800,
        16'h2902, 16'h2c80, 16'h2d80};
    eib_eee_bank #(.LPI_UNIT_CYC(UNIT)) dut (
        .SYS_CLK, .SRST, .CE, .ADDR, .WR, .RD, .WDATA, .RDATA, .TRANSMIT_QUEUE_EMPTY,
        .TRAFFIC_IN, .CAP_MATCH, .PD_FAULT, .RX_PAGE_VALID({1'b0, lp_valid}),
        .RX_PAGE_WORD({16'h0000, lp_rx}), .PARTNER_AN_ABLE, .PARTNER_NP_ABLE, .AN_START,
        .BASE_TOGGLE, .PAGE_SENT, .WAKE_BUSY, .LPI_REQ, .EEE100_EN, .NP_ENABLE, .NP_TX_WORD);
    eib_link_partner lp (.clk(SYS_CLK), .send(lp_send), .word(lp_word), .count(lp_cnt),
        .page_valid(lp_valid), .page_word(lp_rx));
    initial forever #20 SYS_CLK = ~SYS_CLK;
    // ==========================================================
    // Tasks
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs
    task automatic tick(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask : tick
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask : check_byte
    task automatic check_port(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: port %h, expected %h", $time, got, exp);
        end
    endtask : check_port
    // Strobe held one edge, then a quiet cycle so no signal is set twice at once
    task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic r);
        ADDR = a;
        WDATA = d;
        WR = ~r;
        RD = r;
        tick(1);
        WR = 1'b0;
        RD = 1'b0;
        tick(1);
    endtask : bus
    task automatic wrr(input logic [7:0] sel, input logic [7:0] ofs, input logic [7:0] d);
        bus(eib_pkg::A_SEL, sel, 1'b0);
        bus(eib_pkg::A_OFS, ofs, 1'b0);
        bus(eib_pkg::A_DATA, d, 1'b0);
    endtask : wrr
    task automatic rdr(input logic [7:0] sel, input logic [7:0] ofs, input logic [7:0] e);
        bus(eib_pkg::A_SEL, sel, 1'b0);
        bus(eib_pkg::A_OFS, ofs, 1'b0);
        exp_q.push_back(e);
        bus(eib_pkg::A_DATA, 8'h00, 1'b1);
    endtask : rdr
    task automatic burst(input logic [15:0] w, input logic [3:0] n);
        lp_word = w;
        lp_cnt = n;
        lp_send = 1'b1;
        tick(1);
        lp_send = 1'b0;
        tick(int'(n) + 2);
    endtask : burst
    // ==========================================================
    // Result watcher and hang guard
    always @(posedge SYS_CLK) rd_seen <= RD & CE;
    always @(negedge SYS_CLK) begin
        if (rd_seen) begin
            check_byte(RDATA, exp_q.pop_front());
        end
    end
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            end_of_test();
        end
    end
    // ==========================================================
    // Scenarios
    initial begin
        logic [31:0] r;
        logic [7:0] b;
        logic [15:0] w;
        int n;
        tick(5);
        SRST = 1'b0;
        r = xs(32'h0000b31d);
        PARTNER_AN_ABLE = r[1:0];
        PARTNER_NP_ABLE = r[3:2];
        b = 8'h64 | {4'h0, r[2], 2'h0, r[0]};
        check_port(NP_TX_WORD[0], 16'h2001);
        check_port({12'h000, NP_ENABLE}, 16'h000f);
        foreach (gtab[i]) rdr(8'h20, gtab[i][15:8], gtab[i][7:0]);
        foreach (ptab[i]) rdr(8'h23, ptab[i][15:8], ptab[i][7:0]);
        rdr(8'h23, 8'h0d, b);
        rdr(8'h24, 8'h0e, 8'h20);
        $display("test defaults done");
        wrr(8'h20, 8'h38, 8'hff);
        rdr(8'h20, 8'h38, 8'h02);
        wrr(8'h20, 8'h30, 8'hff);
        rdr(8'h20, 8'h30, 8'h40);
        wrr(8'h20, 8'h31, 8'h7f);
        rdr(8'h20, 8'h31, 8'h10);
        wrr(8'h40, 8'h32, 8'hff);
        rdr(8'h20, 8'h32, 8'h00);
        rdr(8'h40, 8'h30, 8'h00);
        rdr(8'h21, 8'h0c, 8'h00);
        exp_q.push_back(8'h00);
        bus(8'h55, 8'h00, 1'b1);
        wrr(8'h20, 8'h33, 8'h01);
        rdr(8'h20, 8'h33, 8'h01);
        r = xs(r);
        wrr(8'h20, 8'h35, r[7:0]);
        rdr(8'h20, 8'h35, {4'h0, r[3:0]});
        check_port({12'h000, NP_ENABLE}, {12'h000, r[3:0]});
        $display("test access done");
        wrr(8'h23, 8'h2d, 8'h83);
        check_port({14'h0000, EEE100_EN}, 16'h0001);
        // Port 4 queue empty too, but its 100BT enable is off
        TRANSMIT_QUEUE_EMPTY = 2'h3;
        n = 0;
        while (LPI_REQ[0] !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        check_port({15'h0000, (n >= 8 && n <= 10)}, 16'h0001);
        check_port({14'h0000, LPI_REQ}, 16'h0001);
        TRAFFIC_IN = 2'h3;
        tick(10);
        check_port({14'h0000, LPI_REQ}, 16'h0001);
        wrr(8'h20, 8'h31, 8'h80);
        tick(1);
        check_port({14'h0000, LPI_REQ}, 16'h0000);
        TRAFFIC_IN = 2'h0;
        $display("test idle done");
        r = xs(r);
        w = r[15:0];
        burst(~w, 4'h2);
        rdr(8'h23, 8'h0d, b);
        burst(w, 4'h3);
        PD_FAULT = 2'h1;
        tick(1);
        PD_FAULT = 2'h0;
        rdr(8'h23, 8'h10, w[15:8] | 8'h40);
        rdr(8'h23, 8'h11, w[7:0]);
        rdr(8'h23, 8'h0d, b | 8'h12);
        rdr(8'h23, 8'h0d, b);
        $display("test pages done");
        BASE_TOGGLE = 2'h1;
        AN_START = 2'h1;
        tick(1);
        AN_START = 2'h0;
        tick(1);
        check_port({15'h0000, NP_TX_WORD[0][11]}, 16'h0000);
        PAGE_SENT = 2'h1;
        tick(1);
        PAGE_SENT = 2'h0;
        tick(1);
        check_port({15'h0000, NP_TX_WORD[0][11]}, 16'h0001);
        // Enable low must freeze the toggle
        CE = 1'b0;
        PAGE_SENT = 2'h1;
        tick(1);
        CE = 1'b1;
        PAGE_SENT = 2'h0;
        check_port({15'h0000, NP_TX_WORD[0][11]}, 16'h0001);
        wrr(8'h23, 8'h0e, 8'hf7);
        check_port(NP_TX_WORD[0], 16'hbf01);
        CAP_MATCH = 2'h2;
        tick(1);
        CAP_MATCH = 2'h0;
        tick(1);
        check_port({14'h0000, EEE100_EN}, 16'h0003);
        $display("test toggle done");
        // Wake exactly at the limit, then one cycle over it
        WAKE_BUSY = 2'h2;
        tick(513);
        WAKE_BUSY = 2'h0;
        tick(2);
        WAKE_BUSY = 2'h2;
        tick(514);
        WAKE_BUSY = 2'h0;
        tick(3);
        rdr(8'h24, 8'h2a, 8'h00);
        rdr(8'h24, 8'h2b, 8'h01);
        rdr(8'h24, 8'h2b, 8'h00);
        $display("test wake done");
        tick(3);
        end_of_test();
    end
endmodule : eib_eee_bank_test
`default_nettype wire
